// >>> common/sdc_pkg.sv
// Constants and types shared by the synthesizer configuration block.
package sdc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register addresses as carried in the register address byte.
    localparam logic [7:0] REG_FB_LOW    = 8'h00;
    localparam logic [7:0] REG_DIV_HIGH  = 8'h01;
    localparam logic [7:0] REG_SIGNATURE = 8'h08;
    localparam logic [7:0] REG_COMMAND   = 8'hf0;
    localparam logic [7:0] READ_NONE     = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Reset contents of the configuration registers and the active dividers.
    localparam logic [7:0] FB_LOW_RST   = 8'hf4;
    localparam logic [6:0] DIV_HIGH_RST = 7'h29;
    localparam logic [9:0] FB_RST       = 10'h1f4;
    localparam logic [2:0] NA_RST       = 3'h2;
    localparam logic       NB_RST       = 1'b0;
    localparam logic       PRE_RST      = 1'b1;
    localparam logic [9:0] FB_STEP      = 10'h001;

    ////////////////////////////////////////////////////////////////////////////
    // Command codes; only the low nibble of a command byte is decoded.
    localparam logic [3:0] CMD_STEP_UP   = 4'h1;
    localparam logic [3:0] CMD_STEP_DOWN = 4'h2;
    localparam logic [3:0] CMD_APPLY     = 4'h4;
    localparam logic [3:0] CMD_READBACK  = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // Serial link framing.
    localparam logic [4:0] SLAVE_ADDR_FIXED = 5'h16;
    localparam logic [3:0] BIT_LAST         = 4'h7;
    localparam logic [3:0] BYTE_BITS        = 4'h8;
    localparam int         LINK_MAX_KBPS    = 400;

    typedef enum logic [2:0]
    {
        SDC_IDLE,
        SDC_ADDR,
        SDC_REG,
        SDC_WDATA,
        SDC_ACK,
        SDC_RDATA,
        SDC_MACK,
        SDC_SKIP
    } sdc_state_t;

    // Every asynchronous input, bundled so that one synchroniser carries them.
    typedef struct packed
    {
        logic       scl;
        logic       sda;
        logic       mrN;
        logic       serial;
        logic       lock;
        logic [1:0] adr;
        logic [9:0] m;
        logic [2:0] na;
        logic       nb;
        logic       p;
    } sdc_pins_t;

endpackage

// >>> verilog/sdc_sync2.sv
// Two-stage synchroniser for a bundle of asynchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module sdc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);

    typedef struct packed
    {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } sdc_sync_t;

    sdc_sync_t q;
    sdc_sync_t d;

    always_comb
    begin
        d.first  = asyncIn;
        d.second = q.first;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign syncOut = q.second;

endmodule
`default_nettype wire

// >>> verilog/sdc_link_sampler.sv
// Data bit capture on the serial clock of the link.
`timescale 1ns/1ps
`default_nettype none
module sdc_link_sampler (
    input  wire logic sclClk,
    input  wire logic sdaIn,
    output logic      sdaBit
);

    typedef struct packed
    {
        logic bitQ;
    } sdc_link_t;

    sdc_link_t q;
    sdc_link_t d;

    // The bit stays put for the whole high phase of the clock, so the main
    // domain reads it only after it has seen the rise through its synchroniser.
    always_comb
    begin
        d.bitQ = sdaIn;
    end

    always_ff @(posedge sclClk)
    begin
        q <= d;
    end

    assign sdaBit = q.bitQ;

endmodule
`default_nettype wire

// >>> verilog/sdc_config.sv
// Divider configuration registers of a clock synthesizer behind a serial slave.
`timescale 1ns/1ps
`default_nettype none
module sdc_config #(
    parameter logic [7:0] SIGNATURE = 8'h3c  // Arbitrary value.
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       sclClk,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    input  wire logic [1:0] adrSel,
    input  wire logic       serialModeSelect,
    input  wire logic       masterClearN,
    input  wire logic [9:0] pinFb,
    input  wire logic [2:0] firstOutputDivisor,
    input  wire logic       secondOutputRatio,
    input  wire logic       pinPre,
    input  wire logic       pllLock,
    output logic      [9:0] fbDivider,
    output logic      [2:0] outDivisor,
    output logic            qbRatio,
    output logic            preDivider,
    output logic            clockRun
);

    ////////////////////////////////////////////////////////////////////////////
    // State of the block.

    typedef struct packed
    {
        sdc_pkg::sdc_state_t st;
        sdc_pkg::sdc_state_t nxt;
        logic [3:0]          cnt;
        logic [7:0]          shift;
        logic [7:0]          regAddr;
        logic [7:0]          tx;
        logic                sdaOe;
        logic                sdaOut;
        logic                sclPrev;
        logic                sdaPrev;
        logic                mrPrev;
        logic                pinLoad;
        logic [7:0]          cfgLow;
        logic [6:0]          cfgHigh;
        logic [9:0]          m;
        logic [2:0]          na;
        logic                nb;
        logic                p;
        logic                clockRun;
    } sdc_cfg_t;

    localparam sdc_cfg_t CFG_RST = '{
        st:       sdc_pkg::SDC_IDLE,
        nxt:      sdc_pkg::SDC_IDLE,
        cnt:      4'h0,
        shift:    8'h00,
        regAddr:  8'h00,
        tx:       8'h00,
        sdaOe:    1'b0,
        sdaOut:   1'b0,
        sclPrev:  1'b0,
        sdaPrev:  1'b0,
        mrPrev:   1'b0,
        pinLoad:  1'b1,
        cfgLow:   sdc_pkg::FB_LOW_RST,
        cfgHigh:  sdc_pkg::DIV_HIGH_RST,
        m:        sdc_pkg::FB_RST,
        na:       sdc_pkg::NA_RST,
        nb:       sdc_pkg::NB_RST,
        p:        sdc_pkg::PRE_RST,
        clockRun: 1'b0
    };

    sdc_cfg_t          q;
    sdc_cfg_t          d;
    sdc_pkg::sdc_pins_t pinsRaw;
    sdc_pkg::sdc_pins_t pins;
    logic              linkBit;
    logic [7:0]        byteIn;
    logic              sclRise;
    logic              sclFall;
    logic              startSeen;
    logic              stopSeen;
    logic              mrRise;
    logic              addrHit;

    ////////////////////////////////////////////////////////////////////////////
    // Register read multiplexer; the command register reads back as zero.

    function automatic logic [7:0] read_reg(
        input logic [7:0] addr,
        input logic [7:0] low,
        input logic [6:0] high,
        input logic       lock
    );
        logic [7:0] data;
        data = sdc_pkg::READ_NONE;
        if (addr == sdc_pkg::REG_FB_LOW)
        begin
            data = low;
        end
        else if (addr == sdc_pkg::REG_DIV_HIGH)
        begin
            data = {high, lock};
        end
        else if (addr == sdc_pkg::REG_SIGNATURE)
        begin
            data = SIGNATURE;
        end
        return data;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Input capture: every pin goes through two flip-flops, the data bit is
    // caught on the link clock itself.

    assign pinsRaw = '{
        scl:    sclClk,
        sda:    sdaIn,
        mrN:    masterClearN,
        serial: serialModeSelect,
        lock:   pllLock,
        adr:    adrSel,
        m:      pinFb,
        na:     firstOutputDivisor,
        nb:     secondOutputRatio,
        p:      pinPre
    };

    sdc_sync2 #(
        .W($bits(sdc_pkg::sdc_pins_t))
    ) sdc_sync2_inst (
        .clk    (mclk),
        .rst    (rst),
        .asyncIn(pinsRaw),
        .syncOut(pins)
    );

    sdc_link_sampler sdc_link_sampler_inst (
        .sclClk(sclClk),
        .sdaIn (sdaIn),
        .sdaBit(linkBit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb
    begin
        d         = q;
        byteIn    = {q.shift[6:0], linkBit};
        sclRise   = pins.scl & ~q.sclPrev;
        sclFall   = ~pins.scl & q.sclPrev;
        startSeen = pins.scl & q.sclPrev & q.sdaPrev & ~pins.sda;
        stopSeen  = pins.scl & q.sclPrev & ~q.sdaPrev & pins.sda;
        mrRise    = pins.mrN & ~q.mrPrev;
        addrHit   = (byteIn[7:1] == {sdc_pkg::SLAVE_ADDR_FIXED, pins.adr});

        d.sclPrev = pins.scl;
        d.sdaPrev = pins.sda;
        d.mrPrev  = pins.mrN;
        d.pinLoad = 1'b0;

        // Only the data line is ever driven; the clock line has no driver.
        if (startSeen)
        begin
            d.st    = sdc_pkg::SDC_ADDR;
            d.cnt   = '0;
            d.sdaOe = 1'b0;
        end
        else if (stopSeen)
        begin
            d.st    = sdc_pkg::SDC_IDLE;
            d.sdaOe = 1'b0;
        end
        else
        begin
            unique case (q.st)
                sdc_pkg::SDC_IDLE,
                sdc_pkg::SDC_SKIP:
                begin
                    d.sdaOe = 1'b0;
                end
                sdc_pkg::SDC_ADDR,
                sdc_pkg::SDC_REG,
                sdc_pkg::SDC_WDATA:
                begin
                    if (sclRise)
                    begin
                        d.shift = byteIn;
                        d.cnt   = q.cnt + 4'h1;
                        if (q.cnt == sdc_pkg::BIT_LAST)
                        begin
                            d.cnt = '0;
                            d.st  = sdc_pkg::SDC_ACK;
                            if (q.st == sdc_pkg::SDC_ADDR)
                            begin
                                if (!addrHit)
                                begin
                                    d.st = sdc_pkg::SDC_SKIP;
                                end
                                else if (byteIn[0])
                                begin
                                    d.nxt = sdc_pkg::SDC_RDATA;
                                    d.tx  = read_reg(q.regAddr, q.cfgLow, q.cfgHigh, pins.lock);
                                end
                                else
                                begin
                                    d.nxt = sdc_pkg::SDC_REG;
                                end
                            end
                            else if (q.st == sdc_pkg::SDC_REG)
                            begin
                                d.regAddr = byteIn;
                                d.nxt     = sdc_pkg::SDC_WDATA;
                            end
                            else
                            begin
                                // One data byte per write; further bytes get no acknowledge.
                                d.nxt = sdc_pkg::SDC_SKIP;
                                if (q.regAddr == sdc_pkg::REG_FB_LOW)
                                begin
                                    d.cfgLow = byteIn;
                                end
                                else if (q.regAddr == sdc_pkg::REG_DIV_HIGH)
                                begin
                                    d.cfgHigh = byteIn[7:1];
                                end
                                else if (q.regAddr == sdc_pkg::REG_COMMAND)
                                begin
                                    if (byteIn[3:0] == sdc_pkg::CMD_STEP_UP)
                                    begin
                                        d.m = q.m + sdc_pkg::FB_STEP;
                                    end
                                    else if (byteIn[3:0] == sdc_pkg::CMD_STEP_DOWN)
                                    begin
                                        d.m = q.m - sdc_pkg::FB_STEP;
                                    end
                                    else if (byteIn[3:0] == sdc_pkg::CMD_APPLY)
                                    begin
                                        d.m  = {q.cfgHigh[6:5], q.cfgLow};
                                        d.na = q.cfgHigh[4:2];
                                        d.nb = q.cfgHigh[1];
                                        d.p  = q.cfgHigh[0];
                                    end
                                    else if (byteIn[3:0] == sdc_pkg::CMD_READBACK)
                                    begin
                                        d.cfgLow  = q.m[7:0];
                                        d.cfgHigh = {q.m[9:8], q.na, q.nb, q.p};
                                    end
                                end
                                // Writes to the signature address change nothing.
                            end
                        end
                    end
                end
                sdc_pkg::SDC_ACK:
                begin
                    if (sclFall)
                    begin
                        if (!q.sdaOe)
                        begin
                            d.sdaOe = 1'b1;
                        end
                        else
                        begin
                            d.st    = q.nxt;
                            d.cnt   = '0;
                            d.sdaOe = (q.nxt == sdc_pkg::SDC_RDATA) & ~q.tx[7];
                        end
                    end
                end
                sdc_pkg::SDC_RDATA:
                begin
                    if (sclRise)
                    begin
                        d.cnt = q.cnt + 4'h1;
                        d.tx  = {q.tx[6:0], 1'b0};
                    end
                    else if (sclFall)
                    begin
                        if (q.cnt == sdc_pkg::BYTE_BITS)
                        begin
                            d.sdaOe = 1'b0;
                            d.st    = sdc_pkg::SDC_MACK;
                        end
                        else
                        begin
                            d.sdaOe = ~q.tx[7];
                        end
                    end
                end
                sdc_pkg::SDC_MACK:
                begin
                    if (sclRise)
                    begin
                        if (!linkBit)
                        begin
                            d.st  = sdc_pkg::SDC_RDATA;
                            d.cnt = '0;
                            d.tx  = read_reg(q.regAddr, q.cfgLow, q.cfgHigh, pins.lock);
                        end
                        else
                        begin
                            d.st = sdc_pkg::SDC_SKIP;
                        end
                    end
                end
            endcase
        end

        // Pins take over at start-up, on clear release and in parallel mode.
        if (q.pinLoad | mrRise | ~pins.serial)
        begin
            d.m  = pins.m;
            d.na = pins.na;
            d.nb = pins.nb;
            d.p  = pins.p;
        end
        d.clockRun = pins.mrN;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            q <= CFG_RST;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign sdaOut     = q.sdaOut;
    assign sdaOe      = q.sdaOe;
    assign fbDivider  = q.m;
    assign outDivisor = q.na;
    assign qbRatio    = q.nb;
    assign preDivider = q.p;
    assign clockRun   = q.clockRun;

endmodule
`default_nettype wire

// >>> bench/sdc_config_checker.sv
// Concurrent checks on the ports of the synthesizer configuration block.
`timescale 1ns/1ps
`default_nettype none
module sdc_config_checker (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       sclClk,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic       serialModeSelect,
    input wire logic       masterClearN,
    input wire logic [9:0] pinFb,
    input wire logic [2:0] firstOutputDivisor,
    input wire logic       secondOutputRatio,
    input wire logic       pinPre,
    input wire logic [9:0] fbDivider,
    input wire logic [2:0] outDivisor,
    input wire logic       qbRatio,
    input wire logic       preDivider,
    input wire logic       clockRun
);
    logic [14:0] pinBus;
    logic [14:0] active;

    assign pinBus = {pinFb, firstOutputDivisor, secondOutputRatio, pinPre};
    assign active = {fbDivider, outDivisor, qbRatio, preDivider};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////
    property p_sda_od;
        !sdaOut;
    endproperty
    a_sda_od: assert property (p_sda_od) else $error("data line driven high");
    property p_oe_rise;
        $rose(sdaOe) |-> !sclClk && !$past(sclClk);
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("data line taken while clock high");
    property p_oe_stable;
        sclClk && $past(sclClk) |-> $stable(sdaOe);
    endproperty
    a_oe_stable: assert property (p_oe_stable) else $error("data line moved while clock high");
    property p_clear_stop;
        !masterClearN [*4] |-> !clockRun;
    endproperty
    a_clear_stop: assert property (p_clear_stop) else $error("outputs run during clear");
    property p_clear_run;
        masterClearN [*6] |-> clockRun;
    endproperty
    a_clear_run: assert property (p_clear_run) else $error("outputs stopped without clear");
    property p_parallel_track;
        (!serialModeSelect && masterClearN && $stable(pinBus)) [*6] |-> active == pinBus;
    endproperty
    a_parallel_track: assert property (p_parallel_track) else $error("dividers not following pins");
    property p_clear_load;
        $rose(masterClearN) ##1 $stable(pinBus) [*6] |-> active == pinBus;
    endproperty
    a_clear_load: assert property (p_clear_load) else $error("pins not loaded at clear release");
    property p_serial_hold;
        (serialModeSelect && masterClearN && sclClk) [*8] |-> $stable(active);
    endproperty
    a_serial_hold: assert property (p_serial_hold) else $error("dividers moved without command");
endmodule

bind sdc_config sdc_config_checker sdc_config_checker_inst (
    .mclk(mclk), .rst(rst), .sclClk(sclClk), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .serialModeSelect(serialModeSelect), .masterClearN(masterClearN), .pinFb(pinFb),
    .firstOutputDivisor(firstOutputDivisor), .secondOutputRatio(secondOutputRatio), .pinPre(pinPre),
    .fbDivider(fbDivider), .outDivisor(outDivisor), .qbRatio(qbRatio), .preDivider(preDivider),
    .clockRun(clockRun)
);
`default_nettype wire

// >>> bench/sdc_i2c_host.sv
// Behavioural serial bus master that clocks register transfers into the block.
`timescale 1ns/1ps
`default_nettype none
module sdc_i2c_host (
    output logic      sclClk,
    output logic      sdaLow,
    input  wire logic sdaLine
);
    // Quarter bit of a 398 kHz clock, kept off the main clock grid.
    localparam int QTR = 627;

    initial
    begin
        sclClk = 1'b1;
        sdaLow = 1'b0;
    end

    ////////////////////////////////////////
    // The clock is only ever released high, never waits on the slave.
    task automatic bitX(input logic b, output logic s);
        sdaLow = !b;
        #QTR sclClk = 1'b1;
        #QTR s = sdaLine;
        #QTR sclClk = 1'b0;
        #QTR;
    endtask

    task automatic start();
        sdaLow = 1'b0;
        #QTR sclClk = 1'b1;
        #QTR sdaLow = 1'b1;
        #QTR sclClk = 1'b0;
        #QTR;
    endtask

    task automatic stop();
        sdaLow = 1'b1;
        #QTR sclClk = 1'b1;
        #QTR sdaLow = 1'b0;
        #QTR;
    endtask

    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bitX(b[i], s);
        end
        bitX(1'b1, s);
        ack = !s;
    endtask

    task automatic recvByte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bitX(1'b1, s);
            b[i] = s;
        end
        bitX(last, s);
    endtask
endmodule
`default_nettype wire

// >>> bench/synth_divider_config_i2c_tb.sv
// Register-level testbench of the synthesizer configuration block.
`timescale 1ns/1ps
`default_nettype none
module synth_divider_config_i2c_tb;
    localparam logic [7:0] SIG = 8'h5a;  // Arbitrary value.

    logic       mclk;
    logic       rst;
    logic       sclClk;
    logic       sdaLow;
    logic       sdaIn;
    logic       sdaOut;
    logic       sdaOe;
    logic [1:0] adrSel;
    logic       serialModeSelect;
    logic       masterClearN;
    logic [9:0] pinFb;
    logic [2:0] firstOutputDivisor;
    logic       secondOutputRatio;
    logic       pinPre;
    logic       pllLock;
    logic [9:0] fbDivider;
    logic [2:0] outDivisor;
    logic       qbRatio;
    logic       preDivider;
    logic       clockRun;
    logic [7:0] rd;
    logic       ack;
    int         error_cnt;
    int         checks;

    // Open-drain line with a pull-up.
    assign sdaIn = !(sdaLow || (sdaOe && !sdaOut));

    sdc_config #(.SIGNATURE(SIG)) sdc_config_inst (
        .mclk(mclk), .rst(rst), .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .adrSel(adrSel), .serialModeSelect(serialModeSelect), .masterClearN(masterClearN),
        .pinFb(pinFb), .firstOutputDivisor(firstOutputDivisor), .secondOutputRatio(secondOutputRatio),
        .pinPre(pinPre), .pllLock(pllLock), .fbDivider(fbDivider), .outDivisor(outDivisor),
        .qbRatio(qbRatio), .preDivider(preDivider), .clockRun(clockRun)
    );

    sdc_i2c_host sdc_i2c_host_inst (.sclClk(sclClk), .sdaLow(sdaLow), .sdaLine(sdaIn));

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = !mclk;
    end

    ////////////////////////////////////////
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic openFrame(input logic [7:0] ra);
        sdc_i2c_host_inst.start();
        sdc_i2c_host_inst.sendByte({5'h16, adrSel, 1'b0}, ack);
        check("write address ack", ack, 1'b1);
        sdc_i2c_host_inst.sendByte(ra, ack);
        check("register byte ack", ack, 1'b1);
    endtask

    task automatic regWrite(input logic [7:0] ra, input logic [7:0] wd);
        openFrame(ra);
        sdc_i2c_host_inst.sendByte(wd, ack);
        check("data byte ack", ack, 1'b1);
        sdc_i2c_host_inst.stop();
        idle(8);
    endtask

    task automatic regRead(input logic [7:0] ra, input logic [7:0] exp);
        openFrame(ra);
        sdc_i2c_host_inst.start();
        sdc_i2c_host_inst.sendByte({5'h16, adrSel, 1'b1}, ack);
        check("read address ack", ack, 1'b1);
        sdc_i2c_host_inst.recvByte(1'b1, rd);
        sdc_i2c_host_inst.stop();
        idle(8);
        check($sformatf("register %h", ra), rd, exp);
    endtask

    task automatic setPins(input logic [9:0] fb, input logic [2:0] na, input logic nb, input logic p);
        @(posedge mclk);
        pinFb <= fb;
        firstOutputDivisor <= na;
        secondOutputRatio <= nb;
        pinPre <= p;
    endtask

    task automatic checkActive(input logic [9:0] fb, input logic [2:0] na, input logic nb, input logic p);
        check("active dividers", {fbDivider, outDivisor, qbRatio, preDivider}, {fb, na, nb, p});
    endtask

    ////////////////////////////////////////
    initial
    begin
        #3_000_000;
        error_cnt++;
        test_done();
    end

    initial
    begin
        rst = 1'b1;
        adrSel = 2'b01;
        serialModeSelect = 1'b1;
        masterClearN = 1'b1;
        pinFb = 10'h155;
        firstOutputDivisor = 3'h1;
        secondOutputRatio = 1'b0;
        pinPre = 1'b1;
        pllLock = 1'b1;
        error_cnt = 0;
        checks = 0;
        idle(20);
        rst <= 1'b0;
        idle(8);
        checkActive(10'h155, 3'h1, 1'b0, 1'b1);
        check("clock running", clockRun, 1'b1);
        regRead(8'h00, 8'hf4);
        regRead(8'h01, {7'b0101001, 1'b1});
        pllLock <= 1'b0;
        regRead(8'h01, {7'b0101001, 1'b0});
        regRead(8'h08, SIG);
        regWrite(8'h08, 8'hff);
        regRead(8'h08, SIG);
        regRead(8'h05, 8'h00);
        regRead(8'hf0, 8'h00);
        $display("test reset values done");

        for (int a = 0; a < 4; a++)
        begin
            @(posedge mclk);
            adrSel <= a[1:0];
            idle(6);
            sdc_i2c_host_inst.start();
            sdc_i2c_host_inst.sendByte({5'h16, a[1:0] ^ 2'b01, 1'b0}, ack);
            check("foreign address ack", ack, 1'b0);
            sdc_i2c_host_inst.start();
            sdc_i2c_host_inst.sendByte({5'h06, a[1:0], 1'b0}, ack);
            check("foreign pattern ack", ack, 1'b0);
            sdc_i2c_host_inst.start();
            sdc_i2c_host_inst.sendByte({5'h16, a[1:0], 1'b1}, ack);
            check("own address ack", ack, 1'b1);
            sdc_i2c_host_inst.recvByte(1'b1, rd);
            check("read direction data", rd, 8'h00);
            sdc_i2c_host_inst.stop();
        end
        $display("test slave address done");

        regWrite(8'h00, 8'h37);
        regWrite(8'h01, 8'ha5);
        regRead(8'h00, 8'h37);
        regRead(8'h01, 8'ha4);
        checkActive(10'h155, 3'h1, 1'b0, 1'b1);
        regWrite(8'hf0, 8'hf4);
        checkActive(10'h237, 3'h4, 1'b1, 1'b0);
        regWrite(8'hf0, 8'ha1);
        checkActive(10'h238, 3'h4, 1'b1, 1'b0);
        regWrite(8'hf0, 8'h52);
        regWrite(8'hf0, 8'h02);
        checkActive(10'h236, 3'h4, 1'b1, 1'b0);
        regWrite(8'hf0, 8'h03);
        checkActive(10'h236, 3'h4, 1'b1, 1'b0);
        openFrame(8'h00);
        sdc_i2c_host_inst.sendByte(8'h11, ack);
        check("first data ack", ack, 1'b1);
        sdc_i2c_host_inst.sendByte(8'h22, ack);
        check("second data refused", ack, 1'b0);
        sdc_i2c_host_inst.start();
        sdc_i2c_host_inst.sendByte({5'h16, adrSel, 1'b1}, ack);
        sdc_i2c_host_inst.recvByte(1'b0, rd);
        check("first read byte", rd, 8'h11);
        sdc_i2c_host_inst.recvByte(1'b1, rd);
        check("repeated read byte", rd, 8'h11);
        sdc_i2c_host_inst.stop();
        idle(8);
        regWrite(8'h01, 8'h00);
        regWrite(8'hf0, 8'h08);
        regRead(8'h00, 8'h36);
        regRead(8'h01, 8'ha4);
        $display("test serial commands done");

        serialModeSelect <= 1'b0;
        setPins(10'h2aa, 3'h5, 1'b1, 1'b0);
        idle(6);
        checkActive(10'h2aa, 3'h5, 1'b1, 1'b0);
        setPins(10'h0c3, 3'h0, 1'b0, 1'b1);
        idle(6);
        checkActive(10'h0c3, 3'h0, 1'b0, 1'b1);
        regWrite(8'hf0, 8'h01);
        checkActive(10'h0c3, 3'h0, 1'b0, 1'b1);
        regWrite(8'hf0, 8'h08);
        regRead(8'h00, 8'hc3);
        regRead(8'h01, 8'h02);
        $display("test parallel mode done");

        serialModeSelect <= 1'b1;
        masterClearN <= 1'b0;
        idle(6);
        check("clock stopped", clockRun, 1'b0);
        setPins(10'h1e1, 3'h3, 1'b1, 1'b1);
        idle(6);
        masterClearN <= 1'b1;
        idle(8);
        checkActive(10'h1e1, 3'h3, 1'b1, 1'b1);
        check("clock restarted", clockRun, 1'b1);
        setPins(10'h100, 3'h2, 1'b0, 1'b0);
        idle(6);
        checkActive(10'h1e1, 3'h3, 1'b1, 1'b1);
        $display("test master clear done");
        test_done();
    end
endmodule
`default_nettype wire
